// >>> pmi_mdio_master.sv
// station management model that sends frames on the management pins
`timescale 1ns/1ps
module pmi_mdio_master (
	input wire logic mclk,
	output logic mdc,
	output logic mdio_in,
	input wire logic mdio_out,
	input wire logic mdio_oe_n
);
	logic drv_bit; // bit the station puts on the line
	logic drv_en; // station drives the line
	// line level: the pull-up wins when nobody drives
	assign mdio_in = drv_en ? drv_bit : (mdio_oe_n ? 1'b1 : mdio_out);
	initial begin
		mdc = 1'b1;
		drv_bit = 1'b1;
		drv_en = 1'b0;
	end
	// one bit: line set while mdc low, line sampled at the rise
	task automatic shift(input logic b, input logic en, output logic s);
		@(posedge mclk);
		mdc <= 1'b0;
		drv_bit <= b;
		drv_en <= en;
		repeat (3) @(posedge mclk);
		@(posedge mclk);
		s = mdio_in;
		mdc <= 1'b1;
		repeat (3) @(posedge mclk);
	endtask
	// whole frame; mdc stands still high between frames
	task automatic frame(input logic [1:0] op, input logic [4:0] phy,
		input logic [4:0] rg, input logic [15:0] wd, output logic [15:0] rd);
		logic [15:0] head;
		logic s;
		head = {2'b01, op, phy, rg, 2'b10};
		rd = 16'h0000;
		// every frame carries its own full preamble
		for (int i = 0; i < 32; i++) shift(1'b1, 1'b1, s);
		for (int i = 15; i >= 2; i--) shift(head[i], 1'b1, s);
		// on reads the station lets go of the line at turnaround
		for (int i = 1; i >= 0; i--) shift(head[i], op == 2'h1, s);
		for (int i = 15; i >= 0; i--) begin
			shift(wd[i], op == 2'h1, s);
			rd[i] = s;
		end
		@(posedge mclk);
		drv_en <= 1'b0;
	endtask
endmodule // pmi_mdio_master

// >>> pmi_mdio_slave.sv
// serial management frame receiver and read-data driver
`timescale 1ns/1ps
module pmi_mdio_slave (
	input wire logic mclk,
	input wire logic reset,
	input wire logic mdc,
	input wire logic mdio_in,
	output logic mdio_out,
	output logic mdio_oe_n,
	pmi_reg_if.frame bus
);

	pmi_pkg::pmi_mdio_state_t state, next_state; // frame position
	logic [4:0] cnt, next_cnt; // bit count within a field
	logic [5:0] pre_cnt, next_pre_cnt; // saturating count of preamble ones
	logic [15:0] shift, next_shift; // header, write data or read data
	logic op_read, next_op_read; // frame is a read
	logic match, next_match; // frame addresses this device
	logic [4:0] addr, next_addr; // latched register offset
	logic mdc_q, next_mdc_q; // previous clock level for edge detect
	logic next_mdio_out, next_mdio_oe_n;
	logic rise; // management clock rising edge
	logic [12:0] full; // header as complete on its last bit

	assign rise = mdc & ~mdc_q;
	assign full = {shift[11:0], mdio_in};
	assign bus.addr = addr;
	assign bus.wdata = shift;
	// read strobe is combinational so the shifter loads in the same cycle
	assign bus.rd_strobe = rise & (state == pmi_pkg::ST_TURNAROUND) &
		(cnt == 5'h00) & op_read & match;

	// ****************************************
	// frame sequencing
	// ****************************************
	// all decisions happen on a sampled rising edge of the management clock
	always_comb begin
		next_state = state;
		next_cnt = cnt;
		next_pre_cnt = pre_cnt;
		next_shift = shift;
		next_op_read = op_read;
		next_match = match;
		next_addr = addr;
		next_mdc_q = mdc;
		next_mdio_out = mdio_out;
		next_mdio_oe_n = mdio_oe_n;
		if (rise) begin
			case (state)
				pmi_pkg::ST_PREAMBLE: begin
					if (mdio_in) begin
						// count ones, saturating at the full preamble
						if (pre_cnt != pmi_pkg::PREAMBLE_BITS)
							next_pre_cnt = pre_cnt + 6'h01;
					end else begin
						// a zero is a start bit only after a full preamble
						if (pre_cnt == pmi_pkg::PREAMBLE_BITS) begin
							next_state = pmi_pkg::ST_HEADER;
							next_cnt = 5'h00;
						end
						next_pre_cnt = 6'h00;
					end
				end
				pmi_pkg::ST_HEADER: begin
					next_shift = {shift[14:0], mdio_in};
					next_cnt = cnt + 5'h01;
					if (cnt == pmi_pkg::HDR_LAST) begin
						next_cnt = 5'h00;
						// bad start or opcode drops the frame
						if (full[12] && (full[11:10] == pmi_pkg::OP_READ ||
							full[11:10] == pmi_pkg::OP_WRITE)) begin
							next_state = pmi_pkg::ST_TURNAROUND;
							next_op_read = (full[11:10] == pmi_pkg::OP_READ);
							next_match = (full[9:5] == bus.phy_address);
							next_addr = full[4:0];
						end else begin
							next_state = pmi_pkg::ST_PREAMBLE;
						end
					end
				end
				pmi_pkg::ST_TURNAROUND: begin
					if (cnt == 5'h00) begin
						next_cnt = 5'h01;
						if (op_read && match) begin
							// take the pin and drive the turnaround zero
							next_shift = bus.rdata;
							next_mdio_oe_n = 1'b0;
							next_mdio_out = 1'b0;
						end
					end else begin
						next_state = pmi_pkg::ST_DATA;
						next_cnt = 5'h00;
						if (op_read && match) begin
							next_mdio_out = shift[15];
							next_shift = {shift[14:0], 1'b0};
						end
					end
				end
				pmi_pkg::ST_DATA: begin
					next_cnt = cnt + 5'h01;
					if (op_read) begin
						next_mdio_out = shift[15];
						next_shift = {shift[14:0], 1'b0};
					end else begin
						next_shift = {shift[14:0], mdio_in};
					end
					if (cnt == pmi_pkg::DATA_LAST) begin
						// master has sampled the last bit: release the pin
						next_state = pmi_pkg::ST_PREAMBLE;
						next_cnt = 5'h00;
						next_mdio_oe_n = 1'b1;
						next_mdio_out = 1'b0;
					end
				end
				default: begin
					next_state = pmi_pkg::ST_PREAMBLE;
				end
			endcase
		end
	end

	// write strobe one cycle after the last data bit, with wdata settled
	logic wr, next_wr;
	always_comb begin
		next_wr = rise & (state == pmi_pkg::ST_DATA) &
			(cnt == pmi_pkg::DATA_LAST) & ~op_read & match;
	end

	// state registers
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			state <= pmi_pkg::ST_PREAMBLE;
			cnt <= 5'h00;
			pre_cnt <= 6'h00;
			shift <= 16'h0000;
			op_read <= 1'b0;
			match <= 1'b0;
			addr <= 5'h00;
			// idle level of the clock, so release gives no false edge
			mdc_q <= 1'b1;
			mdio_out <= 1'b0;
			mdio_oe_n <= 1'b1;
			wr <= 1'b0;
		end else begin
			state <= next_state;
			cnt <= next_cnt;
			pre_cnt <= next_pre_cnt;
			shift <= next_shift;
			op_read <= next_op_read;
			match <= next_match;
			addr <= next_addr;
			mdc_q <= next_mdc_q;
			mdio_out <= next_mdio_out;
			mdio_oe_n <= next_mdio_oe_n;
			wr <= next_wr;
		end
	end

	always_comb begin
		bus.wr_strobe = wr;
	end

endmodule // pmi_mdio_slave

// >>> pmi_mode_irq_regs.sv
// mode override, strap status, expanded control and interrupt register bank
//
// Contract
// - back-to-back repeater needs reduced-mii override too
// - nand-tree override forces pin test mode
// - reduced-mii override resets to one
// - phy address strap field reflects straps
// - strap status register ignores all writes
// - energy-detect power-down disabled by default
// - jabber enable gates jabber onto interrupt
// - receive-error enable gates its interrupt
// - page-received enable gates its interrupt
// - parallel-detect-fault enable gates its interrupt
// - partner-acknowledge enable gates its interrupt
// - link-down enable gates its interrupt
// - status bits set on event, clear on read
`timescale 1ns/1ps
module pmi_mode_irq_regs (
	input wire logic mclk,
	input wire logic reset,
	input wire logic mdc,
	input wire logic mdio_in,
	output logic mdio_out,
	output logic mdio_oe_n,
	input wire logic [1:0] phy_address_strap,
	input wire logic rmii_strap,
	input wire logic [7:0] irq_event,
	output logic irq,
	output logic rmii_mode,
	output logic back_to_back_repeater,
	output logic nand_tree_mode,
	output logic energy_detect_powerdown
);

	// ****************************************
	// storage
	// ****************************************
	pmi_reg_if bus (); // carrier to the frame receiver
	logic [15:0] mode_override, next_mode_override; // offset 16h
	logic [15:0] exp_control, next_exp_control; // offset 18h
	logic [7:0] irq_enable, next_irq_enable; // offset 1bh high byte
	logic [7:0] irq_status, next_irq_status; // offset 1bh low byte
	logic next_irq;
	logic [1:0] phy_strap, next_phy_strap; // sampled address strap
	logic rmii_strap_q, next_rmii_strap_q; // sampled reduced-mii strap
	logic strap_done, next_strap_done; // straps taken once after reset
	logic [15:0] strap_status; // read view of offset 17h

	// ****************************************
	// frame receiver
	// ****************************************
	pmi_mdio_slave u_mdio (
		.mclk(mclk),
		.reset(reset),
		.mdc(mdc),
		.mdio_in(mdio_in),
		.mdio_out(mdio_out),
		.mdio_oe_n(mdio_oe_n),
		.bus(bus.frame)
	);

	assign bus.phy_address = {pmi_pkg::PHY_ADDR_HIGH, phy_strap};

	// ****************************************
	// strap capture
	// ****************************************
	// straps are caught by the clock after release, never by the reset itself
	always_comb begin
		next_strap_done = 1'b1;
		next_phy_strap = phy_strap;
		next_rmii_strap_q = rmii_strap_q;
		if (!strap_done) begin
			next_phy_strap = phy_address_strap;
			next_rmii_strap_q = rmii_strap;
		end
	end

	always_comb begin
		strap_status = 16'h0000;
		strap_status[pmi_pkg::BIT_STRAP_PHY_LO +: 2] = phy_strap;
		strap_status[pmi_pkg::BIT_STRAP_RMII] = rmii_strap_q;
	end

	// ****************************************
	// register writes and status tracking
	// ****************************************
	// writes to the strap status offset fall through the case untouched
	always_comb begin
		next_mode_override = mode_override;
		next_exp_control = exp_control;
		next_irq_enable = irq_enable;
		next_irq_status = irq_status;
		if (bus.wr_strobe) begin
			case (bus.addr)
				// override bits, bit 10 stays zero
				pmi_pkg::OFF_MODE_OVERRIDE: begin
					next_mode_override = bus.wdata &
						pmi_pkg::MODE_OVERRIDE_WMASK;
				end
				// energy_detect_powerdown control with writable reserved bits
				pmi_pkg::OFF_EXP_CONTROL: begin
					next_exp_control = bus.wdata;
				end
				// enables only, status half is read only
				pmi_pkg::OFF_IRQ_CTRL_STATUS: begin
					next_irq_enable = bus.wdata[15:8];
				end
				default: begin
					next_irq_enable = irq_enable;
				end
			endcase
		end
		// clear on read, a same-cycle event still wins
		if (bus.rd_strobe && bus.addr == pmi_pkg::OFF_IRQ_CTRL_STATUS)
			next_irq_status = 8'h00;
		next_irq_status = next_irq_status | irq_event;
	end

	always_comb begin
		next_irq = |(irq_status & irq_enable);
	end

	// read data mux, unmapped offsets read zero
	always_comb begin
		case (bus.addr)
			pmi_pkg::OFF_MODE_OVERRIDE: bus.rdata = mode_override;
			pmi_pkg::OFF_STRAP_STATUS: bus.rdata = strap_status;
			pmi_pkg::OFF_EXP_CONTROL: bus.rdata = exp_control;
			pmi_pkg::OFF_IRQ_CTRL_STATUS: bus.rdata = {irq_enable, irq_status};
			default: bus.rdata = 16'h0000;
		endcase
	end

	// documented reset values, reserved bits included
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			mode_override <= pmi_pkg::MODE_OVERRIDE_RESET;
			exp_control <= pmi_pkg::EXP_CONTROL_RESET;
			irq_enable <= pmi_pkg::IRQ_ENABLE_RESET;
			irq_status <= pmi_pkg::IRQ_STATUS_RESET;
			irq <= 1'b0;
			phy_strap <= pmi_pkg::PHY_STRAP_RESET;
			rmii_strap_q <= 1'b0;
			strap_done <= 1'b0;
		end else begin
			mode_override <= next_mode_override;
			exp_control <= next_exp_control;
			irq_enable <= next_irq_enable;
			irq_status <= next_irq_status;
			irq <= next_irq;
			phy_strap <= next_phy_strap;
			rmii_strap_q <= next_rmii_strap_q;
			strap_done <= next_strap_done;
		end
	end

	// ****************************************
	// mode outputs
	// ****************************************
	assign rmii_mode = mode_override[pmi_pkg::BIT_RMII];
	// repeater mode only valid with reduced-mii selected
	assign back_to_back_repeater = mode_override[pmi_pkg::BIT_B2B] &
		mode_override[pmi_pkg::BIT_RMII];
	// pin test mode regardless of straps
	assign nand_tree_mode = mode_override[pmi_pkg::BIT_NAND];
	// power-saving mode runs when disable bit is clear
	assign energy_detect_powerdown = ~exp_control[pmi_pkg::BIT_ENERGY_DETECT_POWERDOWN_OFF];

	// ****************************************
	// checks
	// ****************************************
	default clocking cb @(posedge mclk); endclocking
	default disable iff (reset);

	// repeater output must follow both written bits, not the b2b bit alone
	property p_b2b_needs_rmii;
		bus.wr_strobe && bus.addr == pmi_pkg::OFF_MODE_OVERRIDE |=>
			back_to_back_repeater ==
			($past(bus.wdata[pmi_pkg::BIT_B2B]) &&
			$past(bus.wdata[pmi_pkg::BIT_RMII]));
	endproperty
	a_b2b_needs_rmii: assert property (p_b2b_needs_rmii)
		else $error("repeater mode without reduced-mii");

	property p_nand_write;
		bus.wr_strobe && bus.addr == pmi_pkg::OFF_MODE_OVERRIDE |=>
			nand_tree_mode == $past(bus.wdata[pmi_pkg::BIT_NAND]);
	endproperty
	a_nand_write: assert property (p_nand_write)
		else $error("nand-tree mode not following write");

	property p_rmii_reset;
		$fell(reset) |-> rmii_mode && !energy_detect_powerdown;
	endproperty
	a_rmii_reset: assert property (@(posedge mclk) p_rmii_reset)
		else $error("override reset values wrong");

	// the view must show the pins as they stood at the capture edge
	property p_strap_view;
		$rose(strap_done) |->
			strap_status[pmi_pkg::BIT_STRAP_PHY_LO +: 2] ==
			$past(phy_address_strap) &&
			strap_status[pmi_pkg::BIT_STRAP_RMII] == $past(rmii_strap);
	endproperty
	a_strap_view: assert property (p_strap_view)
		else $error("strap field mismatch");

	property p_strap_ro;
		strap_done && bus.wr_strobe |=> $stable(strap_status);
	endproperty
	a_strap_ro: assert property (p_strap_ro)
		else $error("strap status changed by write");

	property p_energy_detect_powerdown;
		bus.wr_strobe && bus.addr == pmi_pkg::OFF_EXP_CONTROL |=>
			energy_detect_powerdown == !$past(bus.wdata[pmi_pkg::BIT_ENERGY_DETECT_POWERDOWN_OFF]);
	endproperty
	a_energy_detect_powerdown: assert property (p_energy_detect_powerdown)
		else $error("energy_detect_powerdown control not following write");

	property p_jabber_blocked;
		(irq_enable == 8'h00) ##1 (irq_enable == 8'h00) |-> !irq;
	endproperty
	a_jabber_blocked: assert property (p_jabber_blocked)
		else $error("interrupt with all sources disabled");

	property p_status_set;
		irq_event[7] |=> irq_status[7];
	endproperty
	a_status_set: assert property (p_status_set)
		else $error("event did not set status");

	property p_status_clear;
		bus.rd_strobe && bus.addr == pmi_pkg::OFF_IRQ_CTRL_STATUS &&
			irq_event == 8'h00 |=> irq_status == 8'h00;
	endproperty
	a_status_clear: assert property (p_status_clear)
		else $error("status not cleared by read");

	property p_irq_follow;
		##1 irq == $past(|(irq_status & irq_enable));
	endproperty
	a_irq_follow: assert property (p_irq_follow)
		else $error("interrupt does not follow enabled status");

	c_irq_rise: cover property ($rose(irq));
	c_status_read: cover property (bus.rd_strobe &&
		bus.addr == pmi_pkg::OFF_IRQ_CTRL_STATUS && irq_status != 8'h00);
	c_b2b: cover property ($rose(back_to_back_repeater));
	c_write_override: cover property (bus.wr_strobe &&
		bus.addr == pmi_pkg::OFF_MODE_OVERRIDE);

endmodule // pmi_mode_irq_regs

// >>> pmi_mode_irq_regs_tb.sv
// self-checking testbench of the mode and interrupt register bank
`timescale 1ns/1ps
module pmi_mode_irq_regs_tb;
	// ****************************************
	// signals and instances
	// ****************************************
	localparam logic [4:0] PHY = 5'h03; // own management address
	logic [1:0] strap = 2'h3; // strapped address three
	logic rmii_strap = 1'b1; // reduced-mii strap pin
	logic mclk = 1'b0;
	logic reset = 1'b1;
	logic mdc;
	logic mdio_in;
	logic mdio_out;
	logic mdio_oe_n;
	logic [7:0] irq_event = 8'h00;
	logic irq;
	logic rmii_mode;
	logic back_to_back_repeater;
	logic nand_tree_mode;
	logic energy_detect_powerdown;
	int n_mismatch = 0;
	int n_checks = 0;
	always #2.5 mclk = ~mclk;
	pmi_mode_irq_regs u_pmi_mode_irq_regs (.mclk(mclk), .reset(reset),
		.mdc(mdc), .mdio_in(mdio_in), .mdio_out(mdio_out),
		.mdio_oe_n(mdio_oe_n), .phy_address_strap(strap),
		.rmii_strap(rmii_strap), .irq_event(irq_event), .irq(irq),
		.rmii_mode(rmii_mode),
		.back_to_back_repeater(back_to_back_repeater),
		.nand_tree_mode(nand_tree_mode),
		.energy_detect_powerdown(energy_detect_powerdown));
	pmi_mdio_master u_pmi_mdio_master (.mclk(mclk), .mdc(mdc),
		.mdio_in(mdio_in), .mdio_out(mdio_out), .mdio_oe_n(mdio_oe_n));
	// ****************************************
	// shared tasks
	// ****************************************
	task automatic chk(input logic [15:0] got, input logic [15:0] exp,
		input string what);
		n_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("unexpected at %0t: %s got %h exp %h", $time, what,
				got, exp);
		end
	endtask
	task automatic wr(input logic [4:0] phy, input logic [4:0] rg,
		input logic [15:0] d);
		logic [15:0] r;
		u_pmi_mdio_master.frame(pmi_pkg::OP_WRITE, phy, rg, d, r);
		// update lands two mclk after the last data bit
		repeat (4) @(posedge mclk);
	endtask
	task automatic rchk(input logic [4:0] phy, input logic [4:0] rg,
		input logic [15:0] exp, input string what);
		logic [15:0] r;
		u_pmi_mdio_master.frame(pmi_pkg::OP_READ, phy, rg, 16'h0000, r);
		chk(r, exp, what);
	endtask
	// outputs packed as {rmii, b2b, nand, energy_detect_powerdown}
	function automatic logic [15:0] modes();
		return {12'h000, rmii_mode, back_to_back_repeater, nand_tree_mode,
			energy_detect_powerdown};
	endfunction
	// one-cycle event on one source
	task automatic pulse(input int i);
		@(posedge mclk);
		irq_event <= 8'h01 << i;
		@(posedge mclk);
		irq_event <= 8'h00;
		repeat (4) @(posedge mclk);
	endtask
	// ****************************************
	// scenarios
	// ****************************************
	task automatic t_reset;
		chk(modes(), 16'h0008, "reset outputs");
		rchk(PHY, pmi_pkg::OFF_MODE_OVERRIDE, 16'h0002, "16h reset");
		rchk(PHY, pmi_pkg::OFF_STRAP_STATUS, 16'h6002, "17h reset");
		rchk(PHY, pmi_pkg::OFF_EXP_CONTROL, 16'h0801, "18h reset");
		rchk(PHY, pmi_pkg::OFF_IRQ_CTRL_STATUS, 16'h0000, "1bh");
		$display("test reset done");
	endtask
	task automatic t_mode;
		wr(PHY, pmi_pkg::OFF_MODE_OVERRIDE, 16'h0062);
		chk(modes(), 16'h000e, "b2b nand rmii on");
		rchk(PHY, pmi_pkg::OFF_MODE_OVERRIDE, 16'h0062, "16h back");
		// back-to-back without the reduced-mii bit is not valid
		wr(PHY, pmi_pkg::OFF_MODE_OVERRIDE, 16'h0040);
		chk(modes(), 16'h0000, "b2b alone");
		wr(PHY, pmi_pkg::OFF_MODE_OVERRIDE, 16'hffff);
		rchk(PHY, pmi_pkg::OFF_MODE_OVERRIDE, 16'hfbff, "16h ro");
		wr(PHY, pmi_pkg::OFF_MODE_OVERRIDE, 16'h0002);
		chk(modes(), 16'h0008, "16h restored");
		$display("test mode done");
	endtask
	task automatic t_ro_energy_detect_powerdown;
		wr(PHY, pmi_pkg::OFF_STRAP_STATUS, 16'h0000);
		rchk(PHY, pmi_pkg::OFF_STRAP_STATUS, 16'h6002, "17h write");
		rchk(PHY, 5'h1f, 16'h0000, "unmapped read");
		wr(PHY, pmi_pkg::OFF_EXP_CONTROL, 16'h0001);
		chk(modes(), 16'h0009, "energy_detect_powerdown on");
		// a frame for another address must be ignored
		wr(5'h00, pmi_pkg::OFF_EXP_CONTROL, 16'h0801);
		chk(modes(), 16'h0009, "foreign write");
		rchk(5'h00, pmi_pkg::OFF_EXP_CONTROL, 16'hffff, "foreign read");
		wr(PHY, pmi_pkg::OFF_EXP_CONTROL, 16'h0801);
		chk(modes(), 16'h0008, "energy_detect_powerdown off");
		$display("test ro and energy_detect_powerdown done");
	endtask
	// one source masked with all others on, then alone enabled
	task automatic t_irq;
		logic [15:0] en;
		for (int i = 0; i < 8; i++) begin
			en = 16'h0100 << i;
			wr(PHY, pmi_pkg::OFF_IRQ_CTRL_STATUS, ~en);
			pulse(i);
			chk({15'h0000, irq}, 16'h0000, "masked irq");
			// all enables off; the low byte write must not touch status
			wr(PHY, pmi_pkg::OFF_IRQ_CTRL_STATUS, 16'h00ff);
			rchk(PHY, pmi_pkg::OFF_IRQ_CTRL_STATUS, 16'h0001 << i,
				"status set");
			rchk(PHY, pmi_pkg::OFF_IRQ_CTRL_STATUS, 16'h0000,
				"status cleared");
			wr(PHY, pmi_pkg::OFF_IRQ_CTRL_STATUS, en);
			pulse(i);
			chk({15'h0000, irq}, 16'h0001, "enabled irq");
			rchk(PHY, pmi_pkg::OFF_IRQ_CTRL_STATUS, en | (16'h0001 << i),
				"enable and status");
			repeat (4) @(posedge mclk);
			chk({15'h0000, irq}, 16'h0000, "irq cleared");
		end
		$display("test irq done");
	endtask
	// second reset with the other address strap and no reduced-mii strap
	task automatic t_strap;
		@(posedge mclk);
		reset <= 1'b1;
		strap <= 2'h0;
		rmii_strap <= 1'b0;
		repeat (12) @(posedge mclk);
		reset <= 1'b0;
		repeat (4) @(posedge mclk);
		chk(modes(), 16'h0008, "second reset outputs");
		rchk(5'h00, pmi_pkg::OFF_STRAP_STATUS, 16'h0000, "17h zero");
		// the old address no longer answers
		rchk(PHY, pmi_pkg::OFF_STRAP_STATUS, 16'hffff, "old address");
		rchk(5'h00, pmi_pkg::OFF_IRQ_CTRL_STATUS, 16'h0000, "1bh");
		$display("test strap done");
	endtask
	// ****************************************
	// sequence, watchdog and verdict
	// ****************************************
	task automatic final_report;
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	initial begin
		repeat (12) @(posedge mclk);
		reset <= 1'b0;
		repeat (4) @(posedge mclk);
		t_reset();
		t_mode();
		t_ro_energy_detect_powerdown();
		t_irq();
		t_strap();
		final_report();
	end
	// about seventy frames of some 513 cycles each are expected
	initial begin
		repeat (80000) @(posedge mclk);
		n_mismatch++;
		$display("unexpected at %0t: run did not finish", $time);
		final_report();
	end
endmodule // pmi_mode_irq_regs_tb

// >>> pmi_pkg.sv
// constants and types shared by the mode and interrupt-enable register bank
package pmi_pkg;

	// ****************************************
	// register offsets on the management bus
	// ****************************************
	localparam logic [4:0] OFF_MODE_OVERRIDE = 5'h16; // strap override
	localparam logic [4:0] OFF_STRAP_STATUS = 5'h17; // strap status, read only
	localparam logic [4:0] OFF_EXP_CONTROL = 5'h18; // expanded control
	localparam logic [4:0] OFF_IRQ_CTRL_STATUS = 5'h1b; // enables and status

	// ****************************************
	// reset values and write masks
	// ****************************************
	localparam logic [15:0] MODE_OVERRIDE_RESET = 16'h0002; // reduced-mii on
	localparam logic [15:0] MODE_OVERRIDE_WMASK = 16'hfbff; // bit 10 is ro
	localparam logic [15:0] EXP_CONTROL_RESET = 16'h0801; // energy_detect_powerdown off
	localparam logic [7:0] IRQ_ENABLE_RESET = 8'h00; // all sources blocked
	localparam logic [7:0] IRQ_STATUS_RESET = 8'h00; // nothing pending
	localparam logic [1:0] PHY_STRAP_RESET = 2'h0; // until sampled
	localparam logic [2:0] PHY_ADDR_HIGH = 3'h0; // upper address bits

	// ****************************************
	// field positions
	// ****************************************
	localparam int BIT_B2B = 6; // back-to-back repeater override
	localparam int BIT_NAND = 5; // nand-tree override
	localparam int BIT_RMII = 1; // reduced-mii override
	localparam int BIT_ENERGY_DETECT_POWERDOWN_OFF = 11; // energy-detect power-down disable
	localparam int BIT_STRAP_RMII = 1; // reduced-mii strap status
	localparam int BIT_STRAP_PHY_LO = 13; // phy address strap status low bit

	// ****************************************
	// management frame layout
	// ****************************************
	localparam logic [5:0] PREAMBLE_BITS = 6'h20; // ones before start
	localparam logic [4:0] HDR_LAST = 5'h0c; // 13 bits after first start bit
	localparam logic [4:0] DATA_LAST = 5'h0f; // 16 data bits
	localparam logic [1:0] OP_READ = 2'h2;
	localparam logic [1:0] OP_WRITE = 2'h1;

	// frame receiver states
	typedef enum logic [1:0] {
		ST_PREAMBLE,
		ST_HEADER,
		ST_TURNAROUND,
		ST_DATA
	} pmi_mdio_state_t;

endpackage

// >>> pmi_reg_if.sv
// register access carrier between the frame receiver and the register bank
`timescale 1ns/1ps
interface pmi_reg_if;
	logic rd_strobe; // one-cycle read, rdata sampled the same cycle
	logic wr_strobe; // one-cycle write of wdata
	logic [4:0] addr; // register offset
	logic [15:0] wdata; // write data
	logic [15:0] rdata; // combinational read data
	logic [4:0] phy_address; // own management address
	modport frame (output rd_strobe, wr_strobe, addr, wdata,
		input rdata, phy_address);
	modport bank (input rd_strobe, wr_strobe, addr, wdata,
		output rdata, phy_address);
endinterface // pmi_reg_if
